// File: hdl/cor_common_output.sv
// Common output control and range select bus steering registers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cor_common_output #(
  parameter int NUM_CH = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hard_reset_strobe,
  input  wire logic        soft_reset_strobe,
  input  wire logic        reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        sync_input_first,
  input  wire logic        sync_input_second,
  input  wire logic [3:0]  serial_reset_request,
  input  wire logic [31:0] range_map_table,
  input  wire logic [2:0]  range_code_a,
  input  wire logic [2:0]  range_code_b,
  input  wire logic [2:0]  range_code_c,
  input  wire logic [2:0]  range_code_d,
  input  wire logic        interrupt_event,
  output logic             serial_mode,
  output logic             serial_clock,
  output logic             output_clock_first,
  output logic             output_clock_second,
  output logic             frame_sync_active_low,
  output logic [2:0]       chain_enable,
  output logic             ch0_gain_from_ch3,
  output logic             ch0_gain_external,
  output logic             ch1_gain_from_ch3,
  output logic             ch2_gain_from_ch3,
  output logic             slave_active_valid,
  output logic [15:0]      attenuator_bus
);
  logic [31:0] common_reg, common_next;
  logic [31:0] range_sel_reg, range_sel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        slave_reg, slave_next;
  logic        s1_m1, s1_m2, s1_m3, s2_m1, s2_m2, s2_m3;
  logic        sync1_pulse, sync2_pulse;
  logic [3:0]  sdiv_reg, sdiv_next;
  logic        sclk_reg, sclk_next;
  logic [3:0]  odiv_reg, odiv_next;
  logic        orun_reg, orun_next;
  logic        oclk_reg, oclk_next;
  logic [1:0]  ipulse_reg, ipulse_next;
  logic        clk1_reg, clk1_next, clk2_reg, clk2_next;
  logic [15:0] atten_reg, atten_next;
  logic [7:0]  map_a, map_b, map_c, map_d;
  logic [4:0]  sdiv_limit;
  logic [4:0]  odiv_n;
  logic        wr_common;

  // Nibble pick from the four mapped bytes
  function automatic logic [3:0] pick_nibble(input logic [3:0] sel, input logic [7:0] a,
                                             input logic [7:0] b, input logic [7:0] c,
                                             input logic [7:0] d);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      4'h0: r = a[7:4];
      4'h1: r = a[3:0];
      4'h2: r = b[7:4];
      4'h3: r = b[3:0];
      4'h4: r = c[7:4];
      4'h5: r = c[3:0];
      4'h6: r = d[7:4];
      4'h7: r = d[3:0];
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // Byte lookup: the table port carries 8 bits per block, XORed with that block's code
  function automatic logic [7:0] map_code(input logic [31:0] tbl, input logic [2:0] code,
                                          input int blk);
    logic [7:0] r;
    r = tbl[8 * blk +: 8] ^ {code, code[2:0], code[2:1]};
    return r;
  endfunction

  assign map_a = map_code(range_map_table, range_code_a, 0);
  assign map_b = map_code(range_map_table, range_code_b, 1);
  assign map_c = map_code(range_map_table, range_code_c, 2);
  assign map_d = map_code(range_map_table, range_code_d, 3);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_m1 <= 1'b0;
      s1_m2 <= 1'b0;
      s1_m3 <= 1'b0;
      s2_m1 <= 1'b0;
      s2_m2 <= 1'b0;
      s2_m3 <= 1'b0;
    end
    else
    begin
      s1_m1 <= sync_input_first;
      s1_m2 <= s1_m1;
      s1_m3 <= s1_m2;
      s2_m1 <= sync_input_second;
      s2_m2 <= s2_m1;
      s2_m3 <= s2_m2;
    end
  end
  assign sync1_pulse = s1_m2 & ~s1_m3;
  assign sync2_pulse = s2_m2 & ~s2_m3;
  assign wr_common = reg_write && (reg_addr == cor_pkg::ADDR_COMMON_OUT);

  always_comb
  begin
    common_next = common_reg;
    range_sel_next = range_sel_reg;
    rdata_next = 32'h0000_0000;
    slave_next = slave_reg;
    if (hard_reset_strobe)
    begin
      common_next = cor_pkg::COMMON_OUT_RESET;
      range_sel_next = cor_pkg::RANGE_SEL_RESET;
      slave_next = 1'b0;
    end
    else
    begin
      if (soft_reset_strobe)
        slave_next = 1'b0;
      else if (reg_write)
        slave_next = 1'b1;
      if (wr_common)
        common_next = reg_wdata & cor_pkg::COMMON_OUT_WMASK;
      else if (reg_write)
        range_sel_next = reg_wdata & cor_pkg::RANGE_SEL_WMASK;
      if (reg_read)
        rdata_next = (reg_addr == cor_pkg::ADDR_COMMON_OUT) ? common_reg : range_sel_reg;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      common_reg <= cor_pkg::COMMON_OUT_RESET;
      range_sel_reg <= cor_pkg::RANGE_SEL_RESET;
      rdata_reg <= 32'h0000_0000;
      slave_reg <= 1'b0;
    end
    else
    begin
      common_reg <= common_next;
      range_sel_reg <= range_sel_next;
      rdata_reg <= rdata_next;
      slave_reg <= slave_next;
    end
  end

  // Serial clock divider; limit is half period in cycles
  always_comb
  begin
    sdiv_limit = 5'h0;
    case (common_reg[cor_pkg::BIT_RATE_HI:cor_pkg::BIT_RATE_LO])
      3'h1: sdiv_limit = 5'h1;
      3'h2: sdiv_limit = 5'h1;
      3'h3: sdiv_limit = 5'h2;
      3'h4: sdiv_limit = 5'h4;
      3'h5: sdiv_limit = 5'h8;
      default: sdiv_limit = 5'h0;
    endcase
    sdiv_next = sdiv_reg;
    sclk_next = sclk_reg;
    if (sdiv_limit == 5'h0)
    begin
      sdiv_next = 4'h0;
      sclk_next = ~common_reg[cor_pkg::BIT_SCLK_POL];
    end
    else if (common_reg[cor_pkg::BIT_SCLK_RST] && (|serial_reset_request)
             && (sync1_pulse || sync2_pulse))
    begin
      sdiv_next = 4'h0;
      sclk_next = ~common_reg[cor_pkg::BIT_SCLK_POL];
    end
    // Code 001 toggles every cycle, the fastest a registered clock can run
    else if (common_reg[cor_pkg::BIT_RATE_HI:cor_pkg::BIT_RATE_LO] == 3'h1)
      sclk_next = ~sclk_reg;
    else if ({1'b0, sdiv_reg} + 5'h1 >= sdiv_limit)
    begin
      sdiv_next = 4'h0;
      sclk_next = ~sclk_reg;
    end
    else
      sdiv_next = sdiv_reg + 4'h1;
  end

  // Output clock: divide by N from low nibble plus one, start control
  always_comb
  begin
    odiv_n = {1'b0, common_reg[cor_pkg::BIT_DIV_LO +: 4] & cor_pkg::DIV_LOW_MASK}
             + 5'h1;
    odiv_next = odiv_reg;
    orun_next = orun_reg;
    oclk_next = oclk_reg;
    case (common_reg[cor_pkg::BIT_START_HI:cor_pkg::BIT_START_LO])
      cor_pkg::START_OFF:   orun_next = 1'b0;
      cor_pkg::START_WRITE: orun_next = 1'b1;
      cor_pkg::START_SYNC1: orun_next = orun_reg | sync1_pulse;
      cor_pkg::START_SYNC2: orun_next = orun_reg | sync2_pulse;
      default:              orun_next = 1'b0;
    endcase
    if (!orun_next || (!orun_reg && orun_next))
    begin
      odiv_next = 4'h0;
      oclk_next = 1'b0;
    end
    else if ({1'b0, odiv_reg} + 5'h1 >= odiv_n)
    begin
      odiv_next = 4'h0;
      oclk_next = 1'b0;
    end
    else
    begin
      odiv_next = odiv_reg + 4'h1;
      oclk_next = ({1'b0, odiv_reg} + 5'h1) >= (odiv_n >> 1);
    end
    if (odiv_n == 5'h1)
      oclk_next = orun_next;
    ipulse_next = interrupt_event ? 2'(cor_pkg::INT_PULSE_CYC) :
                  (ipulse_reg != 2'h0) ? ipulse_reg - 2'h1 : 2'h0;
    clk1_next = orun_reg & (oclk_reg ~^ common_reg[cor_pkg::BIT_CLK1_POL]);
    if (common_reg[cor_pkg::BIT_INT_SEL])
      clk2_next = (ipulse_reg != 2'h0) ~^ common_reg[cor_pkg::BIT_CLK2_POL];
    else
      clk2_next = orun_reg & (oclk_reg ~^ common_reg[cor_pkg::BIT_CLK2_POL]);
    atten_next = 16'h0000;
    for (int i = 0; i < 4; i++)
      atten_next[4 * i +: 4] = pick_nibble(range_sel_reg[4 * i +: 4],
                                           map_a, map_b, map_c, map_d);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sdiv_reg <= 4'h0;
      sclk_reg <= ~cor_pkg::COMMON_OUT_RESET[cor_pkg::BIT_SCLK_POL];
      odiv_reg <= 4'h0;
      orun_reg <= 1'b0;
      oclk_reg <= 1'b0;
      ipulse_reg <= 2'h0;
      clk1_reg <= 1'b0;
      clk2_reg <= 1'b0;
      atten_reg <= 16'h0000;
    end
    else
    begin
      sdiv_reg <= sdiv_next;
      sclk_reg <= sclk_next;
      odiv_reg <= odiv_next;
      orun_reg <= orun_next;
      oclk_reg <= oclk_next;
      ipulse_reg <= ipulse_next;
      clk1_reg <= clk1_next;
      clk2_reg <= clk2_next;
      atten_reg <= atten_next;
    end
  end

  // Output fanout; the configuration outputs come straight from the control register
  assign reg_rdata = rdata_reg;
  assign serial_mode = common_reg[cor_pkg::BIT_SER_EN];
  assign serial_clock = sclk_reg;
  assign output_clock_first = clk1_reg;
  assign output_clock_second = clk2_reg;
  assign frame_sync_active_low = common_reg[cor_pkg::BIT_FSYNC_POL];
  assign chain_enable = common_reg[cor_pkg::BIT_CHAIN_LO +: 3];
  assign ch0_gain_external = common_reg[cor_pkg::BIT_CH0_EXT];
  assign ch0_gain_from_ch3 = common_reg[cor_pkg::BIT_CH0_SRC];
  assign ch1_gain_from_ch3 = common_reg[cor_pkg::BIT_CH1_EXT];
  assign ch2_gain_from_ch3 = common_reg[cor_pkg::BIT_CH2_EXT];
  assign slave_active_valid = slave_reg;
  assign attenuator_bus = atten_reg;

  hard_reset_a: assert property (@(posedge clock) disable iff (rst)
    hard_reset_strobe |=> common_reg == cor_pkg::COMMON_OUT_RESET)
    else $error("control register not restored");
  soft_reset_a: assert property (@(posedge clock) disable iff (rst)
    (soft_reset_strobe && !hard_reset_strobe && !wr_common) |=> $stable(common_reg)
    && !slave_reg)
    else $error("soft reset changed control");
  select_reset_a: assert property (@(posedge clock) disable iff (rst)
    hard_reset_strobe |=> range_sel_reg == cor_pkg::RANGE_SEL_RESET)
    else $error("select register not cleared");
  read_data_a: assert property (@(posedge clock) disable iff (rst)
    (reg_read && !hard_reset_strobe && reg_addr == cor_pkg::ADDR_COMMON_OUT)
    |=> reg_rdata == $past(common_reg))
    else $error("read data wrong");
  clock_off_a: assert property (@(posedge clock) disable iff (rst)
    (common_reg[cor_pkg::BIT_START_HI:cor_pkg::BIT_START_LO] == cor_pkg::START_OFF)[*3]
    |-> !output_clock_first)
    else $error("output clock not held");
  sclk_off_a: assert property (@(posedge clock) disable iff (rst)
    (common_reg[cor_pkg::BIT_RATE_HI:cor_pkg::BIT_RATE_LO] == cor_pkg::SCLK_OFF)[*2]
    |-> serial_clock != $past(common_reg[cor_pkg::BIT_SCLK_POL]))
    else $error("serial clock toggles while off");
  sclk_resync_a: assert property (@(posedge clock) disable iff (rst)
    (common_reg[cor_pkg::BIT_SCLK_RST] && (|serial_reset_request) && sync1_pulse)
    |=> serial_clock != $past(common_reg[cor_pkg::BIT_SCLK_POL]))
    else $error("serial clock not resynchronised");
  int_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (interrupt_event && common_reg[cor_pkg::BIT_INT_SEL] && common_reg[cor_pkg::BIT_CLK2_POL])
    ##1 (common_reg[cor_pkg::BIT_INT_SEL] && common_reg[cor_pkg::BIT_CLK2_POL]) |=>
    output_clock_second)
    else $error("interrupt pulse missing");
  nibble_zero_a: assert property (@(posedge clock) disable iff (rst)
    range_sel_reg[15] |=> attenuator_bus[15:12] == 4'h0)
    else $error("nibble not forced to zero");
  start_write_a: assert property (@(posedge clock) disable iff (rst)
    common_reg[9:8] == cor_pkg::START_WRITE |=> orun_reg)
    else $error("output clock did not start");
endmodule
`default_nettype wire

// File: pkg/cor_pkg.sv
// Register map, field positions and reset values of the common output block
package cor_pkg;
  localparam logic [0:0]  ADDR_COMMON_OUT   = 1'h0;
  localparam logic [0:0]  ADDR_RANGE_SELECT = 1'h1;
  localparam logic [31:0] COMMON_OUT_RESET  = 32'h0000_0001;
  localparam logic [31:0] RANGE_SEL_RESET   = 32'h0000_0000;
  localparam logic [31:0] COMMON_OUT_WMASK  = 32'hBE1F_FFFF;
  localparam logic [31:0] RANGE_SEL_WMASK   = 32'h0000_FFFF;
  localparam int BIT_SER_EN     = 31;
  localparam int BIT_SCLK_RST   = 29;
  localparam int BIT_SCLK_POL   = 28;
  localparam int BIT_RATE_HI    = 27;
  localparam int BIT_RATE_LO    = 25;
  localparam int BIT_CHAIN_LO   = 18;
  localparam int BIT_CH0_SRC    = 17;
  localparam int BIT_CH2_EXT    = 16;
  localparam int BIT_CH1_EXT    = 15;
  localparam int BIT_CH0_EXT    = 14;
  localparam int BIT_INT_SEL    = 13;
  localparam int BIT_FSYNC_POL  = 12;
  localparam int BIT_CLK2_POL   = 11;
  localparam int BIT_CLK1_POL   = 10;
  localparam int BIT_START_HI   = 9;
  localparam int BIT_START_LO   = 8;
  localparam int BIT_DIV_HI     = 7;
  localparam int BIT_DIV_LO     = 0;
  localparam int INT_PULSE_CYC  = 2;
  localparam logic [1:0] START_OFF   = 2'h0;
  localparam logic [1:0] START_WRITE = 2'h1;
  localparam logic [1:0] START_SYNC1 = 2'h2;
  localparam logic [1:0] START_SYNC2 = 2'h3;
  localparam logic [2:0] SCLK_OFF    = 3'h0;
  localparam logic [2:0] SCLK_DIV16  = 3'h5;
  localparam logic [3:0] DIV_LOW_MASK = 4'hF;
endpackage

// File: sim/cor_far_side.sv
// Far-side model: attenuator that latches the range control bus
`timescale 1ns/10ps
`default_nettype none
module cor_far_side (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] attenuator_bus,
  output logic      [15:0] atten_latched
);
  // Attenuator takes the bus on every clock
  always_ff @(posedge clock or posedge rst)
    if (rst)
      atten_latched <= 16'h0000;
    else
      atten_latched <= attenuator_bus;
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for common output and range select registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [31:0] WR_MASK = 32'hBE1F_FFFF;
  logic        clock, rst, hard_reset_strobe, soft_reset_strobe, reg_addr;
  logic        reg_write, reg_read, sync_input_first, sync_input_second, interrupt_event;
  logic [31:0] reg_wdata, reg_rdata, range_map_table, d, r;
  logic [3:0]  serial_reset_request;
  logic [2:0]  range_code_a, range_code_b, range_code_c, range_code_d, chain_enable;
  logic        serial_mode, serial_clock, output_clock_first, output_clock_second;
  logic        frame_sync_active_low, ch0_gain_from_ch3, ch0_gain_external;
  logic        ch1_gain_from_ch3, ch2_gain_from_ch3, slave_active_valid;
  logic [15:0] attenuator_bus, atten_latched, s;
  logic [7:0]  t;
  logic [7:0]  divs [3] = '{8'h93, 8'hB7, 8'hED};
  int          bad_count, n_tests, k, e;

  cor_common_output uut (.clock, .rst, .hard_reset_strobe, .soft_reset_strobe, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sync_input_first,
    .sync_input_second, .serial_reset_request, .range_map_table, .range_code_a,
    .range_code_b, .range_code_c, .range_code_d, .interrupt_event, .serial_mode,
    .serial_clock, .output_clock_first, .output_clock_second, .frame_sync_active_low,
    .chain_enable, .ch0_gain_from_ch3, .ch0_gain_external, .ch1_gain_from_ch3,
    .ch2_gain_from_ch3, .slave_active_valid, .attenuator_bus);
  cor_far_side far (.clock, .rst, .attenuator_bus, .atten_latched);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic near(input int c, input int x);
    chk(32'(c >= x - 2 && c <= x + 2), 32'h1);
  endtask

  task automatic wr(input logic a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // One-cycle strobe: 0 soft, 1 hard, 2 first sync, 3 interrupt event, 4 second sync
  task automatic pulse(input int w, input int n);
    @(posedge clock);
    soft_reset_strobe <= (w == 0);
    hard_reset_strobe <= (w == 1);
    sync_input_first  <= (w == 2);
    interrupt_event   <= (w == 3);
    sync_input_second <= (w == 4);
    @(posedge clock);
    {soft_reset_strobe, hard_reset_strobe, sync_input_first, interrupt_event} <= 4'h0;
    sync_input_second <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic rises(input logic w, input int n, output int c);
    logic p;
    logic v;
    c = 0;
    p = w ? output_clock_first : serial_clock;
    repeat (n)
    begin
      @(posedge clock);
      #1;
      v = w ? output_clock_first : serial_clock;
      c += int'(v & ~p);
      p = v;
    end
  endtask

  function automatic logic [15:0] bus_exp(input logic [15:0] sel, input logic [7:0] tv,
                                          input logic [11:0] cd);
    logic [7:0] m;
    logic [2:0] c;
    bus_exp = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      c = cd[3 * sel[4 * i + 1 +: 2] +: 3];
      m = tv ^ {c, c, c[2:1]};
      if (!sel[4 * i + 3])
        bus_exp[4 * i +: 4] = sel[4 * i] ? m[3:0] : m[7:4];
    end
  endfunction

  initial
  begin
    rst = 1'b1;
    {hard_reset_strobe, soft_reset_strobe, reg_addr, reg_write, reg_read} = 5'h00;
    {sync_input_first, sync_input_second, interrupt_event, serial_reset_request} = 7'h00;
    {reg_wdata, range_map_table} = 64'h0;
    {range_code_a, range_code_b, range_code_c, range_code_d} = 12'h000;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    void'($urandom(34));
    rd(1'b0, r);
    chk(r, 32'h0000_0001);
    rd(1'b1, r);
    chk(r, 32'h0000_0000);
    repeat (24)
    begin
      d = $urandom() & WR_MASK;
      if (d[27:26] == 2'h3)
        d[27] = 1'b0;
      serial_reset_request <= 4'($urandom());
      wr(1'b0, d);
      chk(32'(serial_mode), 32'(d[31]));
      chk(32'(chain_enable), 32'(d[20:18]));
      chk(32'(frame_sync_active_low), 32'(d[12]));
      chk(32'({ch2_gain_from_ch3, ch1_gain_from_ch3, ch0_gain_external}), 32'(d[16:14]));
      if (d[14])
        chk(32'(ch0_gain_from_ch3), 32'(d[17]));
      chk(32'(slave_active_valid), 32'h1);
      rd(1'b0, r);
      chk(r, d);
    end
    pulse(0, 2);
    chk(32'(slave_active_valid), 32'h0);
    rd(1'b0, r);
    chk(r, d);
    wr(1'b1, 32'h0000_1357);
    pulse(1, 2);
    rd(1'b0, r);
    chk(r, 32'h0000_0001);
    rd(1'b1, r);
    chk(r, 32'h0000_0000);
    for (k = 0; k < 6; k++)
    begin
      wr(1'b0, 32'h8000_0000 | (32'(k) << 25));
      rises(1'b0, 256, e);
      near(e, k == 0 ? 0 : 256 >> (k == 1 ? 1 : k - 1));
    end
    serial_reset_request <= 4'h2;
    wr(1'b0, 32'hAA00_0000);
    pulse(2, 1);
    s = 16'h0000;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clock);
      #1;
      s[k] = serial_clock;
    end
    chk(32'(s), 32'h0000_00FF);
    foreach (divs[i])
    begin
      wr(1'b0, {22'h0, 2'h1, divs[i]});
      rises(1'b1, 256, e);
      near(e, 256 / (int'(divs[i][3:0]) + 1));
    end
    wr(1'b0, 32'h0000_0093);
    rises(1'b1, 64, e);
    chk(32'(e), 32'h0);
    wr(1'b0, 32'h0000_0293);
    rises(1'b1, 64, e);
    chk(32'(e), 32'h0);
    pulse(2, 0);
    rises(1'b1, 256, e);
    near(e, 64);
    wr(1'b0, 32'h0000_0093);
    wr(1'b0, 32'h0000_0393);
    pulse(2, 0);
    rises(1'b1, 64, e);
    chk(32'(e), 32'h0);
    pulse(4, 0);
    rises(1'b1, 256, e);
    near(e, 64);
    for (k = 0; k < 2; k++)
    begin
      wr(1'b0, 32'h0000_2000 | (32'(k) << 11));
      pulse(3, 0);
      e = 0;
      repeat (16)
      begin
        e += int'(output_clock_second == k[0]);
        @(posedge clock);
        #1;
      end
      chk(32'(e), 32'h2);
    end
    for (k = 0; k < 16; k++)
    begin
      t = (k < 8) ? 8'h00 : 8'($urandom());
      s = {4'(k), 4'(15 - k), 4'(k ^ 5), 4'(k ^ 10)};
      @(posedge clock);
      range_map_table <= {4{t}};
      {range_code_d, range_code_c, range_code_b, range_code_a} <= 12'($urandom());
      wr(1'b1, {16'h0000, s});
      chk(32'(atten_latched), 32'(bus_exp(s, t, {range_code_d, range_code_c, range_code_b, range_code_a})));
      rd(1'b1, r);
      chk(r, {16'h0000, s});
    end
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
